// >>> dv/hsis_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module hsis_assertions #(
  parameter int STRETCH_CYC = 2000,
  parameter int TSU_CYC     = 13,
  parameter int DIV         = 217
) (
  // core
  input wire logic clock,
  input wire logic rst,
  // link
  input wire logic if_sel,
  input wire logic a_d2h,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic miso_oe,
  input wire logic scl_d_oe,
  input wire logic sda_d_oe
);
  int   hold_q, age_q, run_q;
  logic sda_p_q, a_p_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // stretch length; counted, a repeat would be too long
  always_ff @(posedge clock) hold_q <= (rst || !scl_d_oe) ? 0 : hold_q + 1;
  // age of sda drive, as seen at release
  always_ff @(posedge clock) begin
    sda_p_q <= sda_d_oe;
    age_q   <= (sda_d_oe != sda_p_q) ? 1 : age_q + 1;
  end
  // length of each level on the async line
  always_ff @(posedge clock) begin
    a_p_q <= a_d2h;
    run_q <= (a_d2h != a_p_q) ? 1 : run_q + 1;
  end
  property p_miso_off; if_sel |-> !miso_oe; endproperty
  a_miso_off: assert property (p_miso_off) else $error("miso on in async mode");
  property p_miso_cs; miso_oe == (!cs_n && !if_sel); endproperty
  a_miso_cs: assert property (p_miso_cs) else $error("miso enable wrong for select and frame");
  property p_tw_off; !if_sel |-> !scl_d_oe && !sda_d_oe; endproperty
  a_tw_off: assert property (p_tw_off) else $error("two-wire driven in spi mode");
  property p_tx_off; !if_sel |-> a_d2h; endproperty
  a_tx_off: assert property (p_tx_off) else $error("async tx in spi mode");
  property p_sck_idle; cs_n |-> !sck; endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck high outside frame");
  property p_stretch; hold_q <= STRETCH_CYC; endproperty
  a_stretch: assert property (p_stretch) else $error("scl held too long");
  property p_tsu; $fell(scl_d_oe) |-> age_q >= TSU_CYC; endproperty
  a_tsu: assert property (p_tsu) else $error("sda set too late");
  property p_baud; $rose(a_d2h) |-> run_q % DIV == 0; endproperty
  a_baud: assert property (p_baud) else $error("async bit length off");
endmodule
`default_nettype wire

// >>> dv/hsis_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module hsis_tb_top;
  import hsis_pkg::*;
  localparam int STRETCH = 2000;
  logic        clock, rst_h, rst_d, use_spi, a_tx, a_rx, spi_go, spi_busy, i2c_go, i2c_rd;
  logic        i2c_busy, i2c_nack, tx_valid, tx_ready, rx_valid, rx_err, spi_rx_valid;
  logic        i2c_tx_valid, i2c_tx_taken, i2c_rx_valid, spi_mode, usb_en, sb_q, ib_q;
  logic [15:0] baud_div;
  hsis_byte_t  spi_wbyte, spi_rbyte, i2c_wbyte, i2c_rbyte, tx_data, rx_data;
  hsis_byte_t  spi_tx_byte, spi_rx_byte, i2c_tx_byte, i2c_rx_byte, exp_q[$];
  int          bad_count, tests_run, cyc, r;
  hsis_link_if link ();
  hsis_host hsis_host_i (.clock, .rst(rst_h), .link, .use_spi, .a_tx, .a_rx, .spi_go, .spi_wbyte,
    .spi_busy, .spi_rbyte, .i2c_go, .i2c_rd, .i2c_wbyte, .i2c_busy, .i2c_nack, .i2c_rbyte);
  hsis_device #(.STRETCH_CYC(STRETCH)) hsis_device_i (.clock, .rst(rst_d), .link, .baud_div, .tx_data,
    .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_err, .spi_tx_byte, .spi_rx_byte, .spi_rx_valid,
    .i2c_tx_byte, .i2c_tx_valid, .i2c_tx_taken, .i2c_rx_byte, .i2c_rx_valid, .spi_mode, .usb_en);
  hsis_assertions #(.STRETCH_CYC(STRETCH)) hsis_assertions_i (.clock, .rst(rst_d),
    .if_sel(link.if_sel), .a_d2h(link.a_d2h), .sck(link.sck), .cs_n(link.cs_n),
    .miso_oe(link.miso_oe), .scl_d_oe(link.scl_d_oe), .sda_d_oe(link.sda_d_oe));
  // clock
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  // loopback: device frames come back to its receiver
  always @(posedge clock) a_tx <= a_rx;
  task automatic chk8(input string n, input hsis_byte_t e, input hsis_byte_t s);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic s);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %b got %b", n, e, s);
    end
  endtask
  task automatic take(input string n, input hsis_byte_t s);
    hsis_byte_t e;
    e = exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX;
    chk8(n, e, s);
  endtask
  task automatic finish_test();
    // notes that never met a result count as one miss
    if (exp_q.size() != 0) bad_count++;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // result watcher and hang guard
  always @(posedge clock) begin
    sb_q <= spi_busy;
    ib_q <= i2c_busy;
    cyc++;
    if (rx_err === 1'b1) chk1("rx_err", 0, rx_err);
    if (rx_valid === 1'b1) take("rx_data", rx_data);
    if (i2c_rx_valid === 1'b1) take("i2c_rx_byte", i2c_rx_byte);
    if (spi_rx_valid === 1'b1) take("spi_rx_byte", spi_rx_byte);
    if (sb_q === 1'b1 && spi_busy === 1'b0) take("spi_rbyte", spi_rbyte);
    if (ib_q === 1'b1 && i2c_busy === 1'b0 && i2c_rd === 1'b1) take("i2c_rbyte", i2c_rbyte);
    if (cyc == 90000) begin
      bad_count++;
      finish_test();
    end
  end
  function automatic hsis_byte_t rb();
    return hsis_byte_t'($urandom);
  endfunction
  function automatic bit cnd(input int s);
    case (s)
      0: return spi_busy === 1'b0 && i2c_busy === 1'b0;
      1: return link.scl_d_oe === 1'b1;
      2: return i2c_tx_taken === 1'b1;
      3: return tx_ready === 1'b1;
      default: return exp_q.size() == 0;
    endcase
  endfunction
  // bounded wait, always at least one edge
  task automatic till(input int s);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (n < 30000 && !cnd(s));
    // a wait that runs out is a failure
    if (!cnd(s)) bad_count++;
  endtask
  // host released first so the device samples a settled select
  task automatic boot(input logic spi);
    rst_h <= 1;
    rst_d <= 1;
    use_spi <= spi;
    repeat (4) @(posedge clock);
    rst_h <= 0;
    repeat (4) @(posedge clock);
    rst_d <= 0;
    repeat (3) @(posedge clock);
    chk1("spi_mode", spi, spi_mode);
  endtask
  task automatic tx(input hsis_byte_t b);
    till(3);
    tx_data <= b;
    tx_valid <= 1;
    exp_q.push_back(b);
    @(posedge clock);
    tx_valid <= 0;
  endtask
  // late: reply only after the device has stretched a while
  task automatic i2c(input logic rd, input logic late, input logic nk);
    hsis_byte_t b;
    b = rb();
    // first bit low so the setup check sees sda move
    if (late) b[7] = 1'b0;
    i2c_rd <= rd;
    i2c_wbyte <= b;
    i2c_tx_byte <= b;
    i2c_go <= 1;
    if (!rd && !nk) exp_q.push_back(b);
    if (rd) exp_q.push_back(late ? b : 8'hFF);
    @(posedge clock);
    i2c_go <= 0;
    if (rd && late) begin
      till(1);
      repeat (300) @(posedge clock);
      i2c_tx_valid <= 1;
      till(2);
      i2c_tx_valid <= 0;
    end
    till(0);
    chk1("i2c_nack", nk, i2c_nack);
  endtask
  // cs high time kept between frames
  task automatic spi_x();
    hsis_byte_t w, q;
    w = rb();
    q = rb();
    repeat (8) @(posedge clock);
    spi_wbyte <= w;
    spi_tx_byte <= q;
    spi_go <= 1;
    exp_q.push_back(w);
    exp_q.push_back(q);
    @(posedge clock);
    spi_go <= 0;
    till(0);
  endtask
  initial begin
    {rst_h, rst_d} <= 2'h3;
    // below the floor: must clamp to the fastest rate
    baud_div <= 16'h0064;
    {use_spi, spi_go, i2c_go, i2c_rd, tx_valid, i2c_tx_valid} <= '0;
    {spi_wbyte, i2c_wbyte, tx_data, spi_tx_byte, i2c_tx_byte} <= '0;
    r = $urandom(32'hF7A2);
    boot(0);
    chk1("usb_en", 1, usb_en);
    tx(rb());
    baud_div <= 16'h00D9;
    tx(rb());
    till(4);
    $display("test 1 done");
    i2c(0, 0, 0);
    i2c(1, 1, 0);
    i2c(1, 0, 0);
    $display("test 2 done");
    boot(1);
    spi_x();
    spi_x();
    tx_valid <= 1;
    repeat (20) @(posedge clock);
    chk1("tx_ready", 0, tx_ready);
    tx_valid <= 0;
    i2c(0, 0, 1);
    till(4);
    $display("test 3 done");
    finish_test();
  end
endmodule
`default_nettype wire

// >>> logic/hsis_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsis_params.svh"
module hsis_device #(
  parameter int STRETCH_CYC = `HSIS_STRETCH_CYC,
  parameter int TSU_CYC     = `HSIS_TSU_CYC
) (
  // core
  input  wire logic             clock,
  input  wire logic             rst,
  // link
  hsis_link_if.dev              link,
  // async port
  input  wire logic [15:0]      baud_div,
  input  wire hsis_pkg::hsis_byte_t tx_data,
  input  wire logic             tx_valid,
  output logic                  tx_ready,
  output hsis_pkg::hsis_byte_t  rx_data,
  output logic                  rx_valid,
  output logic                  rx_err,
  // four-wire port
  input  wire hsis_pkg::hsis_byte_t spi_tx_byte,
  output hsis_pkg::hsis_byte_t  spi_rx_byte,
  output logic                  spi_rx_valid,
  // two-wire port
  input  wire hsis_pkg::hsis_byte_t i2c_tx_byte,
  input  wire logic             i2c_tx_valid,
  output logic                  i2c_tx_taken,
  output hsis_pkg::hsis_byte_t  i2c_rx_byte,
  output logic                  i2c_rx_valid,
  // status
  output logic                  spi_mode,
  output logic                  usb_en
);
  import hsis_pkg::*;

  localparam int SW = $clog2(STRETCH_CYC + 1);
  // the load cycle and the setup wait must fit inside the stretch bound
  if (STRETCH_CYC <= TSU_CYC + 2 || TSU_CYC < 1) $error("timing counts out of range");

  // -----------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------
  logic [1:0] sel_s, rxd_s, cs_s, rxt_s;
  logic [2:0] scl_s, sda_s;
  logic       rxt_q3;
  logic       rx_tgl_q;
  always_ff @(posedge clock) begin
    sel_s  <= {sel_s[0], link.if_sel};
    rxd_s  <= {rxd_s[0], link.a_h2d};
    cs_s   <= {cs_s[0], link.cs_n};
    rxt_s  <= {rxt_s[0], rx_tgl_q};
    rxt_q3 <= rxt_s[1];
    scl_s  <= {scl_s[1:0], link.scl};
    sda_s  <= {sda_s[1:0], link.sda};
  end

  // -----------------------------------------------------------
  // port assignment
  // -----------------------------------------------------------
  logic armed_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      armed_q  <= 1'b0;
      spi_mode <= 1'b0;
      usb_en   <= 1'b0;
    end else begin
      usb_en <= 1'b1;
      if (!armed_q) begin
        armed_q  <= 1'b1;
        // high or open keeps async port
        spi_mode <= !sel_s[1];
      end
    end
  end

  // -----------------------------------------------------------
  // async port, 8N1, no rts/cts
  // -----------------------------------------------------------
  logic [15:0] div;
  // clamp divisor to the rate range
  always_comb begin
    div = baud_div;
    if (baud_div < 16'(`HSIS_DIV_LO)) div = 16'(`HSIS_DIV_LO);
    if (baud_div > 16'(`HSIS_DIV_HI)) div = 16'(`HSIS_DIV_HI);
  end

  logic [15:0] tc_q;
  logic [3:0]  tb_q;
  logic [8:0]  tsh_q;
  logic        tbusy_q;
  // whole-cycle divisor, error far under 1%
  always_ff @(posedge clock) begin
    if (rst) begin
      tbusy_q    <= 1'b0;
      tx_ready   <= 1'b0;
      link.a_d2h <= 1'b1;
      tc_q       <= 16'h0000;
      tb_q       <= 4'h0;
      tsh_q      <= 9'h1FF;
    end else if (!tbusy_q) begin
      // async port silent when four-wire owns pins
      tx_ready   <= armed_q && !spi_mode && !(tx_valid && tx_ready);
      link.a_d2h <= 1'b1;
      if (tx_valid && tx_ready) begin
        tbusy_q    <= 1'b1;
        link.a_d2h <= 1'b0;
        tsh_q      <= {1'b1, tx_data};
        tc_q       <= div - 16'h0001;
        tb_q       <= 4'h0;
      end
    end else if (tc_q != 16'h0000) begin
      tc_q <= tc_q - 16'h0001;
    end else begin
      tc_q <= div - 16'h0001;
      tb_q <= tb_q + 4'h1;
      // eight data bits then one stop
      if (tb_q == 4'(`HSIS_DATA_BITS + 1)) begin
        tbusy_q <= 1'b0;
      end else begin
        link.a_d2h <= tsh_q[0];
        tsh_q      <= {1'b1, tsh_q[8:1]};
      end
    end
  end

  logic [15:0] rc_q;
  logic [3:0]  rb_q;
  logic [7:0]  rsh_q;
  logic        rbusy_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      rbusy_q  <= 1'b0;
      rx_valid <= 1'b0;
      rx_err   <= 1'b0;
      rx_data  <= 8'h00;
      rc_q     <= 16'h0000;
      rb_q     <= 4'h0;
      rsh_q    <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      rx_err   <= 1'b0;
      if (!rbusy_q) begin
        if (armed_q && !spi_mode && !rxd_s[1]) begin
          rbusy_q <= 1'b1;
          rc_q    <= {1'b0, div[15:1]};
          rb_q    <= 4'h0;
        end
      end else if (rc_q != 16'h0000) begin
        rc_q <= rc_q - 16'h0001;
      end else begin
        rc_q <= div - 16'h0001;
        rb_q <= rb_q + 4'h1;
        if (rb_q == 4'h0 && rxd_s[1]) begin
          rbusy_q <= 1'b0;
        end else if (rb_q == 4'(`HSIS_DATA_BITS + 1)) begin
          rbusy_q  <= 1'b0;
          rx_valid <= rxd_s[1];
          rx_err   <= !rxd_s[1];
          rx_data  <= rsh_q;
        end else if (rb_q != 4'h0) begin
          rsh_q <= {rxd_s[1], rsh_q[7:1]};
        end
      end
    end
  end

  // -----------------------------------------------------------
  // four-wire slave, link clock domain
  // -----------------------------------------------------------
  logic [2:0] bit_q, ph_q;
  logic [6:0] ssh_q;
  hsis_byte_t rx_hold_q, spi_tx_q;
  // sck and cs always from host
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_q <= 3'h0;
      ssh_q <= 7'h00;
    end else begin
      bit_q <= bit_q + 3'h1;
      ssh_q <= {ssh_q[5:0], link.mosi};
    end
  end

  // byte hand-off by toggle
  always_ff @(posedge link.sck or posedge rst) begin
    if (rst) begin
      rx_tgl_q  <= 1'b0;
      rx_hold_q <= 8'h00;
    end else if (bit_q == 3'h7) begin
      rx_tgl_q  <= !rx_tgl_q;
      rx_hold_q <= {ssh_q, link.mosi};
    end
  end

  always_ff @(negedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      ph_q <= 3'h0;
    end else begin
      ph_q <= bit_q;
    end
  end
  assign link.miso    = spi_tx_q[3'h7 - ph_q];
  assign link.miso_oe = spi_mode && !link.cs_n;

  // core side: take received byte, refresh reply
  always_ff @(posedge clock) begin
    if (rst) begin
      spi_rx_valid <= 1'b0;
      spi_rx_byte  <= 8'h00;
      spi_tx_q     <= 8'h00;
    end else begin
      spi_rx_valid <= spi_mode && (rxt_s[1] != rxt_q3);
      if (rxt_s[1] != rxt_q3) begin
        spi_rx_byte <= rx_hold_q;
      end
      // word is stable while sck is busy with other bits
      if (cs_s[1] || rxt_s[1] != rxt_q3) begin
        spi_tx_q <= spi_tx_byte;
      end
    end
  end

  // -----------------------------------------------------------
  // two-wire slave
  // -----------------------------------------------------------
  hsis_tw_state_t tw_q;
  logic [3:0]     tn_q;
  hsis_byte_t     tsr_q;
  logic           rw_q, ld_q;
  logic [SW-1:0]  st_cnt_q;
  logic           rise, fall, start, stop;
  // fast-mode edges seen via 15 ns sync
  assign rise  = scl_s[1] && !scl_s[2];
  assign fall  = !scl_s[1] && scl_s[2];
  assign start = scl_s[1] && scl_s[2] && !sda_s[1] && sda_s[2];
  assign stop  = scl_s[1] && scl_s[2] && sda_s[1] && !sda_s[2];
  assign link.scl_d_o = 1'b0;
  assign link.sda_d_o = 1'b0;

  // slave only, never drives clock high
  always_ff @(posedge clock) begin
    if (rst) begin
      tw_q          <= TW_IDLE;
      link.scl_d_oe <= 1'b0;
      link.sda_d_oe <= 1'b0;
      i2c_rx_valid  <= 1'b0;
      i2c_rx_byte   <= 8'h00;
      i2c_tx_taken  <= 1'b0;
      tn_q     <= 4'h0;
      tsr_q    <= 8'h00;
      rw_q     <= 1'b0;
      ld_q     <= 1'b0;
      st_cnt_q <= '0;
    end else begin
      i2c_rx_valid <= 1'b0;
      i2c_tx_taken <= 1'b0;
      // no two-wire activity in four-wire mode
      if (!armed_q || spi_mode || stop) begin
        tw_q          <= TW_IDLE;
        link.scl_d_oe <= 1'b0;
        link.sda_d_oe <= 1'b0;
      end else if (start) begin
        tw_q          <= TW_ADDR;
        tn_q          <= 4'h0;
        link.scl_d_oe <= 1'b0;
        link.sda_d_oe <= 1'b0;
      end else begin
        case (tw_q)
          TW_IDLE: tw_q <= TW_IDLE;
          TW_ADDR, TW_WDATA: begin
            if (rise) begin
              tsr_q <= {tsr_q[6:0], sda_s[1]};
              tn_q  <= tn_q + 4'h1;
            end
            if (fall && tn_q == 4'h8) begin
              if (tw_q == TW_WDATA) begin
                link.sda_d_oe <= 1'b1;
                i2c_rx_valid  <= 1'b1;
                i2c_rx_byte   <= tsr_q;
                tw_q          <= TW_WACK;
              end else if (tsr_q[7:1] == `HSIS_I2C_ADDR) begin
                link.sda_d_oe <= 1'b1;
                rw_q          <= tsr_q[0];
                tw_q          <= TW_AACK;
              end else begin
                tw_q <= TW_IDLE;
              end
            end
          end
          TW_AACK, TW_WACK: begin
            if (fall) begin
              link.sda_d_oe <= 1'b0;
              tn_q          <= 4'h0;
              if (tw_q == TW_AACK && rw_q) begin
                link.scl_d_oe <= 1'b1;
                ld_q     <= 1'b0;
                st_cnt_q <= '0;
                tw_q     <= TW_STRETCH;
              end else begin
                tw_q <= TW_WDATA;
              end
            end
          end
          TW_STRETCH: begin
            st_cnt_q <= st_cnt_q + SW'(1);
            // give up early enough that load plus setup still ends inside the bound
            if (!ld_q && (i2c_tx_valid || st_cnt_q >= SW'(STRETCH_CYC - TSU_CYC - 2))) begin
              ld_q          <= 1'b1;
              tsr_q         <= i2c_tx_valid ? i2c_tx_byte : 8'hFF;
              i2c_tx_taken  <= i2c_tx_valid;
              link.sda_d_oe <= i2c_tx_valid && !i2c_tx_byte[7];
              st_cnt_q      <= '0;
            end
            if (ld_q && st_cnt_q == SW'(TSU_CYC)) begin
              link.scl_d_oe <= 1'b0;
              tn_q          <= 4'h0;
              tw_q          <= TW_RDATA;
            end
          end
          TW_RDATA: begin
            if (fall) begin
              tn_q <= tn_q + 4'h1;
              if (tn_q == 4'h7) begin
                link.sda_d_oe <= 1'b0;
                tw_q          <= TW_RACK;
              end else begin
                link.sda_d_oe <= !tsr_q[6];
                tsr_q         <= {tsr_q[6:0], 1'b1};
              end
            end
          end
          TW_RACK: begin
            if (rise) begin
              rw_q <= !sda_s[1];
            end
            if (fall) begin
              if (rw_q) begin
                link.scl_d_oe <= 1'b1;
                ld_q     <= 1'b0;
                st_cnt_q <= '0;
                tw_q     <= TW_STRETCH;
              end else begin
                tw_q <= TW_IDLE;
              end
            end
          end
          default: tw_q <= TW_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> logic/hsis_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsis_params.svh"
module hsis_host #(
  parameter int SCK_HALF = `HSIS_SCK_HALF_MIN
) (
  // core
  input  wire logic             clock,
  input  wire logic             rst,
  // link
  hsis_link_if.host             link,
  // port choice and async passthrough
  input  wire logic             use_spi,
  input  wire logic             a_tx,
  output logic                  a_rx,
  // four-wire master
  input  wire logic             spi_go,
  input  wire hsis_pkg::hsis_byte_t spi_wbyte,
  output logic                  spi_busy,
  output hsis_pkg::hsis_byte_t  spi_rbyte,
  // two-wire master
  input  wire logic             i2c_go,
  input  wire logic             i2c_rd,
  input  wire hsis_pkg::hsis_byte_t i2c_wbyte,
  output logic                  i2c_busy,
  output logic                  i2c_nack,
  output hsis_pkg::hsis_byte_t  i2c_rbyte
);
  import hsis_pkg::*;

  // -----------------------------------------------------------
  // checks and pin synchronisers
  // -----------------------------------------------------------
  // sck limit
  if (SCK_HALF < `HSIS_SCK_HALF_MIN || SCK_HALF > 256) $error("sck half period out of range");
  logic [1:0] miso_s, scl_s, sda_s, ad_s;
  always_ff @(posedge clock) begin
    miso_s <= {miso_s[0], link.miso_bus};
    scl_s  <= {scl_s[0], link.scl};
    sda_s  <= {sda_s[0], link.sda};
    ad_s   <= {ad_s[0], link.a_d2h};
  end

  // select and async pins, idle high like the pull-ups
  always_ff @(posedge clock) begin
    if (rst) begin
      link.if_sel <= 1'b1;
      link.a_h2d  <= 1'b1;
      a_rx        <= 1'b1;
    end else begin
      link.if_sel <= !use_spi;
      link.a_h2d  <= a_tx;
      a_rx        <= ad_s[1];
    end
  end

  // -----------------------------------------------------------
  // four-wire master, sck from a divider
  // -----------------------------------------------------------
  logic [7:0]  h_q;
  logic [4:0]  e_q;
  logic [7:0]  sh_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      link.cs_n <= 1'b1;
      link.sck  <= 1'b0;
      link.mosi <= 1'b0;
      spi_busy  <= 1'b0;
      spi_rbyte <= 8'h00;
      h_q       <= 8'h00;
      e_q       <= 5'h00;
      sh_q      <= 8'h00;
    end else if (!spi_busy) begin
      if (spi_go) begin
        spi_busy  <= 1'b1;
        link.cs_n <= 1'b0;
        link.mosi <= spi_wbyte[7];
        sh_q      <= spi_wbyte;
        h_q       <= 8'h00;
        e_q       <= 5'h00;
      end
    end else if (h_q != 8'(SCK_HALF - 1)) begin
      h_q <= h_q + 8'h01;
    end else begin
      h_q <= 8'h00;
      e_q <= e_q + 5'h01;
      if (e_q == 5'h10) begin
        link.cs_n <= 1'b1;
        spi_busy  <= 1'b0;
        spi_rbyte <= sh_q;
      end else if (e_q < 5'h10) begin
        link.sck <= !link.sck;
        if (!link.sck) begin
          sh_q <= {sh_q[6:0], miso_s[1]};
        end else begin
          link.mosi <= sh_q[7];
        end
      end
    end
  end

  // -----------------------------------------------------------
  // two-wire master, one fixed slave address
  // -----------------------------------------------------------
  hsis_hm_state_t st_q;
  logic [9:0]     t_q;
  logic [4:0]     n_q;
  logic [17:0]    tx_q, rx_q;
  logic           rd_q, ph_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      st_q          <= HM_IDLE;
      link.scl_h_o  <= 1'b0;
      link.sda_h_o  <= 1'b0;
      link.scl_h_oe <= 1'b0;
      link.sda_h_oe <= 1'b0;
      i2c_busy      <= 1'b0;
      i2c_nack      <= 1'b0;
      i2c_rbyte     <= 8'h00;
      t_q <= 10'h000;
      n_q <= 5'h00;
      tx_q <= 18'h00000;
      rx_q <= 18'h00000;
      rd_q <= 1'b0;
      ph_q <= 1'b0;
    end else begin
      t_q <= t_q + 10'h001;
      case (st_q)
        HM_IDLE: begin
          if (i2c_go) begin
            i2c_busy <= 1'b1;
            rd_q     <= i2c_rd;
            tx_q     <= {`HSIS_I2C_ADDR, i2c_rd, 1'b1, i2c_rd ? 8'hFF : i2c_wbyte, 1'b1};
            link.sda_h_oe <= 1'b1;
            t_q  <= 10'h000;
            st_q <= HM_START;
          end
        end
        HM_START: begin
          if (t_q == 10'(`HSIS_SCL_LOW_CYC)) begin
            link.scl_h_oe <= 1'b1;
            t_q  <= 10'h000;
            n_q  <= 5'h00;
            st_q <= HM_LOW;
          end
        end
        HM_LOW: begin
          if (t_q == 10'(`HSIS_SCL_LOW_CYC / 2)) begin
            link.sda_h_oe <= !tx_q[17];
          end
          if (t_q == 10'(`HSIS_SCL_LOW_CYC)) begin
            link.scl_h_oe <= 1'b0;
            t_q  <= 10'h000;
            st_q <= HM_HIGH;
          end
        end
        HM_HIGH: begin
          if (!scl_s[1]) begin
            t_q <= 10'h000;
          end else if (t_q == 10'(`HSIS_SCL_HIGH_CYC)) begin
            rx_q <= {rx_q[16:0], sda_s[1]};
            tx_q <= {tx_q[16:0], 1'b1};
            link.scl_h_oe <= 1'b1;
            n_q  <= n_q + 5'h01;
            t_q  <= 10'h000;
            ph_q <= 1'b0;
            st_q <= (n_q == 5'h11) ? HM_STOP : HM_LOW;
          end
        end
        HM_STOP: begin
          if (t_q == 10'(`HSIS_SCL_LOW_CYC / 2) && !ph_q) begin
            link.sda_h_oe <= 1'b1;
          end
          if (t_q == 10'(`HSIS_SCL_LOW_CYC) && !ph_q) begin
            link.scl_h_oe <= 1'b0;
            ph_q <= 1'b1;
            t_q  <= 10'h000;
          end
          if (ph_q && scl_s[1] && t_q == 10'(`HSIS_SCL_HIGH_CYC)) begin
            link.sda_h_oe <= 1'b0;
            i2c_busy  <= 1'b0;
            i2c_nack  <= rx_q[9] | (!rd_q & rx_q[0]);
            i2c_rbyte <= rx_q[8:1];
            st_q <= HM_IDLE;
          end
        end
        default: st_q <= HM_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> pkg/hsis_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hsis_link_if;
  logic if_sel;
  logic a_h2d;
  logic a_d2h;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic scl_d_o;
  logic scl_d_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl_h_o;
  logic scl_h_oe;
  logic sda_h_o;
  logic sda_h_oe;
  wire  scl;
  wire  sda;
  wire  miso_bus;
  // scl and sda open-drain with pull-up; miso_bus pulled high when miso_oe is low
  assign scl = !((scl_d_oe && !scl_d_o) || (scl_h_oe && !scl_h_o));
  assign sda = !((sda_d_oe && !sda_d_o) || (sda_h_oe && !sda_h_o));
  assign miso_bus = miso_oe ? miso : 1'b1;
  modport dev (
    input  if_sel, a_h2d, sck, cs_n, mosi, scl, sda,
    output a_d2h, miso, miso_oe, scl_d_o, scl_d_oe, sda_d_o, sda_d_oe
  );
  modport host (
    output if_sel, a_h2d, sck, cs_n, mosi, scl_h_o, scl_h_oe, sda_h_o, sda_h_oe,
    input  a_d2h, miso_bus, scl, sda
  );
endinterface
`default_nettype wire

// >>> pkg/hsis_params.svh
`ifndef HSIS_PARAMS_SVH
`define HSIS_PARAMS_SVH
// core clock
`define HSIS_CLK_HZ 200000000
`define HSIS_CLK_PS 5000
// async port rates
`define HSIS_BAUD_DEF 38400
`define HSIS_BAUD_MIN 9600
`define HSIS_BAUD_MAX 921600
`define HSIS_DIV_DEF (`HSIS_CLK_HZ / `HSIS_BAUD_DEF)
`define HSIS_DIV_HI (`HSIS_CLK_HZ / `HSIS_BAUD_MIN)
`define HSIS_DIV_LO (`HSIS_CLK_HZ / `HSIS_BAUD_MAX)
`define HSIS_DATA_BITS 8
// two-wire timing
`define HSIS_TSU_PS 62500
`define HSIS_TSU_CYC ((`HSIS_TSU_PS + `HSIS_CLK_PS - 1) / `HSIS_CLK_PS)
`define HSIS_STRETCH_MS 20
`define HSIS_STRETCH_CYC (`HSIS_STRETCH_MS * (`HSIS_CLK_HZ / 1000))
`define HSIS_SCL_LOW_NS 1600
`define HSIS_SCL_HIGH_NS 900
`define HSIS_SCL_LOW_CYC ((`HSIS_SCL_LOW_NS * 1000 + `HSIS_CLK_PS - 1) / `HSIS_CLK_PS)
`define HSIS_SCL_HIGH_CYC ((`HSIS_SCL_HIGH_NS * 1000 + `HSIS_CLK_PS - 1) / `HSIS_CLK_PS)
`define HSIS_I2C_ADDR 7'h42
// four-wire clock limit
`define HSIS_SCK_MAX_HZ 5500000
`define HSIS_SCK_HALF_MIN ((`HSIS_CLK_HZ + 2 * `HSIS_SCK_MAX_HZ - 1) / (2 * `HSIS_SCK_MAX_HZ))
`endif

// >>> pkg/hsis_pkg.sv
package hsis_pkg;
  typedef logic [7:0] hsis_byte_t;
  // device two-wire slave states
  typedef enum logic [2:0] {
    TW_IDLE, TW_ADDR, TW_AACK, TW_WDATA, TW_WACK, TW_STRETCH, TW_RDATA, TW_RACK
  } hsis_tw_state_t;
  // host two-wire master states
  typedef enum logic [2:0] {
    HM_IDLE, HM_START, HM_LOW, HM_HIGH, HM_STOP
  } hsis_hm_state_t;
endpackage
